//--- common/jcl_pkg.sv
// types for the jump, call and load execution slice
// assumes the regs header is included where constants are needed
`default_nettype none
package jcl_pkg;
   typedef enum logic [2:0] {
      jcl_idle, jcl_disp_lo, jcl_disp_hi, jcl_src, jcl_dst, jcl_exec
   } jcl_state_t;
   typedef enum logic [2:0] {
      jcl_k_jtrap, jcl_k_long_relative_call, jcl_k_long_relative_jump, jcl_k_ldw, jcl_k_ldb,
      jcl_k_load_byte_sign_extended, jcl_k_load_byte_zero_extended
   } jcl_kind_t;
   // one instruction stream byte
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } jcl_byte_t;
   // register file / memory write request
   typedef struct packed {
      logic reg_we;
      logic reg_byte;
      logic [7:0] reg_addr;
      logic [15:0] reg_data;
      logic mem_we;
      logic [15:0] mem_addr;
      logic [15:0] mem_data;
   } jcl_wr_t;
   typedef struct packed {
      jcl_state_t st;
      jcl_kind_t kind;
      logic [1:0] amode;
      logic [15:0] disp;
      logic [15:0] src;
      logic [15:0] pc;
      logic [15:0] sp;
      logic trap_flag;
      logic busy;
      logic done;
      logic unknown;
      jcl_wr_t wr;
   } jcl_st_t;
endpackage
`default_nettype wire

//--- common/jcl_regs.svh
// constants for the jump, call and load execution slice
// assumes a 16-bit core with byte-wide instruction stream
`ifndef JCL_REGS_SVH
`define JCL_REGS_SVH
`define JCL_OP_JTRAP 8'hdc
`define JCL_OP_LONG_RELATIVE_CALL 8'hef
`define JCL_OP_LONG_RELATIVE_JUMP 8'he7
`define JCL_OP_LDW 6'h28
`define JCL_OP_LDB 6'h2c
`define JCL_OP_LOAD_BYTE_SIGN_EXTENDED 6'h2f
`define JCL_OP_LOAD_BYTE_ZERO_EXTENDED 6'h2b
`define JCL_SP_STEP 16'h0002
`define JCL_HI_ONES 8'hff
`define JCL_HI_ZERO 8'h00
`define JCL_SP_RESET 16'h0000
`define JCL_PC_RESET 16'h0000
`endif

//--- logic/jcl_exec.sv
// decode and execute for trap jump, long call/jump and the loads
// assumes: bytes arrive one per valid cycle; pc points past last byte
// taken; source operand value is resolved outside from the opcode mode bits
// assumes: one clock, reset low and asynchronous; the stack write and
// register write strobes are taken by the core in the cycle they stand
`default_nettype none
`include "jcl_regs.svh"
// Notes on behaviour
// - trap flag clear: fall through
// - trap flag set: clear flag, jump
// - short displacement sign-extended to 16 bits
// - call: sp minus 2, push return pc, jump
// - call displacement is signed 16-bit
// - word load copies source word
// - byte load copies source byte
// - sign-extend byte load fills high byte
// - zero-extend byte load clears high byte
// - long jump adds signed displacement, no stack
module jcl_exec (
   input wire logic clk,
   input wire logic nrst,
   input wire jcl_pkg::jcl_byte_t ibyte,
   input wire logic [15:0] src_value,
   input wire logic trap_set,
   output logic [15:0] pc,
   output logic [15:0] sp,
   output logic overflow_trap_flag,
   output logic busy,
   output logic done,
   output logic unknown_op,
   output logic [1:0] src_mode,
   output jcl_pkg::jcl_wr_t wr
);
   jcl_pkg::jcl_st_t s_reg;
   jcl_pkg::jcl_st_t s_next;
   // address of the byte after the one taken this cycle
   logic [15:0] pc_inc;

   // ==========================================================
   // next state
   // byte order of each instruction:
   //   trap jump: opcode, one displacement byte
   //   long call and jump: opcode, displacement low, then high
   //   loads: opcode, one operand byte, destination register byte
   // the exec state takes no byte, so the stream holds its byte there
   always_comb begin
      // pulses and write strobes last one cycle
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.unknown = 1'b0;
      s_next.wr = '0;
      pc_inc = s_reg.pc + 16'h0001;

      // the alu sets the trap flag; a set wins over any clear below
      if (trap_set) begin
         s_next.trap_flag = 1'b1;
      end

      unique case (s_reg.st)
         jcl_pkg::jcl_idle: begin
            // opcode byte; one outside the slice is skipped and reported
            if (ibyte.valid) begin
               s_next.pc = pc_inc;
               s_next.amode = ibyte.data[1:0];
               s_next.busy = 1'b1;
               s_next.st = jcl_pkg::jcl_src;
               if (ibyte.data == `JCL_OP_JTRAP) begin
                  s_next.kind = jcl_pkg::jcl_k_jtrap;
                  s_next.st = jcl_pkg::jcl_disp_lo;
               end else if (ibyte.data == `JCL_OP_LONG_RELATIVE_CALL) begin
                  s_next.kind = jcl_pkg::jcl_k_long_relative_call;
                  s_next.st = jcl_pkg::jcl_disp_lo;
               end else if (ibyte.data == `JCL_OP_LONG_RELATIVE_JUMP) begin
                  s_next.kind = jcl_pkg::jcl_k_long_relative_jump;
                  s_next.st = jcl_pkg::jcl_disp_lo;
               end else if (ibyte.data[7:2] == `JCL_OP_LDW) begin
                  s_next.kind = jcl_pkg::jcl_k_ldw;
               end else if (ibyte.data[7:2] == `JCL_OP_LDB) begin
                  s_next.kind = jcl_pkg::jcl_k_ldb;
               end else if (ibyte.data[7:2] == `JCL_OP_LOAD_BYTE_SIGN_EXTENDED) begin
                  s_next.kind = jcl_pkg::jcl_k_load_byte_sign_extended;
               end else if (ibyte.data[7:2] == `JCL_OP_LOAD_BYTE_ZERO_EXTENDED) begin
                  s_next.kind = jcl_pkg::jcl_k_load_byte_zero_extended;
               end else begin
                  s_next.unknown = 1'b1;
                  s_next.busy = 1'b0;
                  s_next.st = jcl_pkg::jcl_idle;
               end
            end
         end

         jcl_pkg::jcl_disp_lo: begin
            // first displacement byte, sign-filled for the trap jump
            if (ibyte.valid) begin
               s_next.pc = pc_inc;
               // short jump displacement sign-extended
               s_next.disp = {{8{ibyte.data[7]}}, ibyte.data};
               s_next.st = (s_reg.kind == jcl_pkg::jcl_k_jtrap) ?
                  jcl_pkg::jcl_exec : jcl_pkg::jcl_disp_hi;
            end
         end

         jcl_pkg::jcl_disp_hi: begin
            // high byte replaces the sign fill of the low byte
            if (ibyte.valid) begin
               s_next.pc = pc_inc;
               s_next.disp = {ibyte.data, s_reg.disp[7:0]};
               s_next.st = jcl_pkg::jcl_exec;
            end
         end

         jcl_pkg::jcl_src: begin
            // operand byte(s) per mode are resolved outside
            if (ibyte.valid) begin
               s_next.pc = pc_inc;
               s_next.src = src_value;
               s_next.st = jcl_pkg::jcl_dst;
            end
         end

         jcl_pkg::jcl_dst: begin
            // destination register byte ends the load
            if (ibyte.valid) begin
               s_next.pc = pc_inc;
               s_next.wr.reg_we = 1'b1;
               s_next.wr.reg_addr = ibyte.data;
               s_next.wr.reg_byte = 1'b0;
               unique case (s_reg.kind)
                  jcl_pkg::jcl_k_ldb: begin
                     s_next.wr.reg_byte = 1'b1;
                     s_next.wr.reg_data = {`JCL_HI_ZERO,
                        s_reg.src[7:0]};
                  end
                  jcl_pkg::jcl_k_load_byte_sign_extended: begin
                     s_next.wr.reg_data = {s_reg.src[7] ? `JCL_HI_ONES :
                        `JCL_HI_ZERO, s_reg.src[7:0]};
                  end
                  jcl_pkg::jcl_k_load_byte_zero_extended: begin
                     s_next.wr.reg_data = {`JCL_HI_ZERO,
                        s_reg.src[7:0]};
                  end
                  jcl_pkg::jcl_k_ldw: begin
                     s_next.wr.reg_data = s_reg.src;
                  end
                  default: begin
                     // only loads reach this state; write nothing
                     s_next.wr.reg_we = 1'b0;
                  end
               endcase
               s_next.done = 1'b1;
               s_next.busy = 1'b0;
               s_next.st = jcl_pkg::jcl_idle;
            end
         end

         jcl_pkg::jcl_exec: begin
            // branch or push; no byte is taken in this cycle
            s_next.done = 1'b1;
            s_next.busy = 1'b0;
            s_next.st = jcl_pkg::jcl_idle;
            unique case (s_reg.kind)
               jcl_pkg::jcl_k_jtrap: begin
                  if (s_reg.trap_flag) begin
                     // a trap set in this very cycle keeps the flag
                     s_next.trap_flag = trap_set;
                     s_next.pc = s_reg.pc + s_reg.disp;
                  end
                  // flag clear: pc already past the instruction
               end
               jcl_pkg::jcl_k_long_relative_call: begin
                  // push the address just past the call
                  s_next.sp = s_reg.sp - `JCL_SP_STEP;
                  s_next.wr.mem_we = 1'b1;
                  s_next.wr.mem_addr = s_reg.sp - `JCL_SP_STEP;
                  s_next.wr.mem_data = s_reg.pc;
                  s_next.pc = s_reg.pc + s_reg.disp;
               end
               jcl_pkg::jcl_k_long_relative_jump: begin
                  // the stack is left alone
                  s_next.pc = s_reg.pc + s_reg.disp;
               end
               default: begin
                  // loads end in the dst state and never get here
               end
            endcase
         end

         default: begin
            // unused state codes fall back to idle
            s_next.st = jcl_pkg::jcl_idle;
            s_next.busy = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // state register
   // reset loads constants only; idle is the all-zero state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
         s_reg.pc <= `JCL_PC_RESET;
         s_reg.sp <= `JCL_SP_RESET;
         s_reg.st <= jcl_pkg::jcl_idle;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   assign pc = s_reg.pc;
   assign sp = s_reg.sp;
   assign overflow_trap_flag = s_reg.trap_flag;
   assign busy = s_reg.busy;
   assign done = s_reg.done;
   assign unknown_op = s_reg.unknown;
   assign src_mode = s_reg.amode;
   assign wr = s_reg.wr;
endmodule
`default_nettype wire

//--- sim/jcl_exec_props.sv
// checker for the jump, call and load execution slice
// assumes it is bound to jcl_exec and sees only its ports
`default_nettype none
module jcl_exec_props (
   input wire logic clk,
   input wire logic nrst,
   input wire jcl_pkg::jcl_byte_t ibyte,
   input wire logic trap_set,
   input wire logic [15:0] sp,
   input wire logic overflow_trap_flag,
   input wire logic busy,
   input wire logic done,
   input wire jcl_pkg::jcl_wr_t wr
);
   // =====
   // opcode of the instruction in progress
   logic [7:0] op_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         op_reg <= 8'h00;
      else if (ibyte.valid && !busy)
         op_reg <= ibyte.data;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_load_done: assert property (wr.reg_we |-> done)
      else $error("write without done");
   a_call_sp: assert property (wr.mem_we |->
      sp == $past(sp) - 16'h0002) else $error("stack step wrong");
   a_push_addr: assert property (wr.mem_we |->
      done && wr.mem_addr == sp) else $error("push address wrong");
   a_jump_stack: assert property (done && op_reg == 8'he7 |->
      !wr.mem_we && sp == $past(sp)) else $error("long jump hit stack");
   a_trap_clear: assert property (done && op_reg == 8'hdc &&
      !$past(trap_set) |-> !overflow_trap_flag) else $error("flag kept");
   a_zext_high: assert property (wr.reg_we && op_reg[7:2] == 6'h2b |->
      wr.reg_data[15:8] == 8'h00) else $error("high byte not zero");
   a_sext_high: assert property (wr.reg_we && op_reg[7:2] == 6'h2f |->
      wr.reg_data[15:8] == {8{wr.reg_data[7]}}) else $error("bad sign fill");
   a_byte_sel: assert property (wr.reg_we |->
      wr.reg_byte == (op_reg[7:2] == 6'h2c)) else $error("byte select wrong");
   c_push: cover property (wr.mem_we);
   c_byte: cover property (wr.reg_we && wr.reg_byte);
   c_trap: cover property (done && op_reg == 8'hdc);
endmodule
bind jcl_exec jcl_exec_props jcl_exec_props_i (.clk(clk), .nrst(nrst),
   .ibyte(ibyte), .trap_set(trap_set), .sp(sp), .busy(busy), .done(done),
   .overflow_trap_flag(overflow_trap_flag), .wr(wr));
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the jump, call and load execution slice
// assumes jcl_exec and its checker are compiled before it
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] op;
      logic [15:0] src;
      logic [15:0] res;
   } jcl_row_t;
   logic clk = 0, nrst = 0, trap_set = 0;
   jcl_pkg::jcl_byte_t ibyte = '0;
   logic [15:0] src_value = 16'h0000, pc, sp, epc, ret;
   logic overflow_trap_flag, busy, done, unknown_op;
   logic [1:0] src_mode;
   jcl_pkg::jcl_wr_t wr;
   int n_mismatch = 0, tests_run = 0, cyc = 0, i;
   jcl_row_t rows [6] = '{'{8'ha0, 16'h8001, 16'h8001},
      '{8'ha3, 16'h1234, 16'h1234}, '{8'hb1, 16'h77c5, 16'h00c5},
      '{8'hbd, 16'h3480, 16'hff80}, '{8'hbc, 16'h107f, 16'h007f},
      '{8'hae, 16'h12f0, 16'h00f0}};
   jcl_exec jcl_exec_i (.clk(clk), .nrst(nrst), .ibyte(ibyte),
      .src_value(src_value), .trap_set(trap_set), .pc(pc), .sp(sp),
      .overflow_trap_flag(overflow_trap_flag), .busy(busy), .done(done),
      .unknown_op(unknown_op), .src_mode(src_mode), .wr(wr));
   always #2.5 clk = ~clk;
   // =====
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] b);
      @(negedge clk);
      ibyte.valid = 1'b1;
      ibyte.data = b;
   endtask
   // release the stream, then wait for the completion pulse
   task automatic fin;
      int k;
      @(negedge clk);
      ibyte.valid = 1'b0;
      for (k = 0; k < 8 && done !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic results;
      $display("tests %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         results;
      end
   end
   // =====
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) nrst = 1'b1;
      chk(sp, 16'h0000);
      epc = 16'h0000;
      for (i = 0; i < 6; i++) begin
         src_value = rows[i].src;
         put(rows[i].op);
         put(8'h10);
         put(8'h20);
         fin;
         epc += 16'h0003;
         chk(wr.reg_data, rows[i].res);
         chk({15'h0000, wr.reg_we}, 16'h0001);
         chk({8'h00, wr.reg_addr}, 16'h0020);
         chk({15'h0000, busy}, 16'h0000);
         chk({14'h0000, src_mode}, {14'h0000, rows[i].op[1:0]});
         chk(pc, epc);
         $display("load row %0d done", i);
      end
      put(8'hdc);
      put(8'h05);
      fin;
      epc += 16'h0002;
      chk(pc, epc);
      @(negedge clk) trap_set = 1'b1;
      @(negedge clk) trap_set = 1'b0;
      chk({15'h0000, overflow_trap_flag}, 16'h0001);
      put(8'hdc);
      put(8'h80);
      fin;
      epc += 16'hff82;
      chk(pc, epc);
      chk({15'h0000, overflow_trap_flag}, 16'h0000);
      $display("trap jumps done");
      put(8'hef);
      put(8'h00);
      chk({15'h0000, busy}, 16'h0001);
      put(8'h80);
      fin;
      ret = epc + 16'h0003;
      epc = ret + 16'h8000;
      chk(wr.mem_addr, 16'hfffe);
      chk(wr.mem_data, ret);
      chk(pc, epc);
      $display("long call done");
      put(8'he7);
      put(8'hff);
      put(8'h7f);
      fin;
      epc += 16'h8002;
      chk(pc, epc);
      chk(sp, 16'hfffe);
      $display("long jump done");
      put(8'h00); // opcode outside the slice
      @(posedge clk);
      #1;
      epc += 16'h0001;
      chk({15'h0000, unknown_op}, 16'h0001);
      chk({15'h0000, busy}, 16'h0000);
      chk(pc, epc);
      @(negedge clk) ibyte.valid = 1'b0;
      $display("unknown opcode done");
      @(negedge clk) trap_set = 1'b1;
      @(negedge clk) trap_set = 1'b0;
      put(8'hdc);
      put(8'h02);
      // the alu sets the flag again in the exec cycle: the set wins
      @(negedge clk) trap_set = 1'b1;
      fin;
      trap_set = 1'b0;
      epc += 16'h0004;
      chk(pc, epc);
      chk({15'h0000, overflow_trap_flag}, 16'h0001);
      $display("trap set wins done");
      put(8'ha0);
      @(negedge clk);
      nrst = 1'b0;
      ibyte.valid = 1'b0;
      @(negedge clk) nrst = 1'b1;
      chk(pc, 16'h0000);
      chk(sp, 16'h0000);
      chk({14'h0000, overflow_trap_flag, busy}, 16'h0000);
      put(8'ha0);
      put(8'h10);
      put(8'h20);
      fin;
      chk(wr.reg_data, 16'h12f0);
      chk(pc, 16'h0003);
      $display("mid-run reset done");
      results;
   end
endmodule
`default_nettype wire
